// >>> vpw_link_control_regs.sv
// Purpose: Control registers of a single-wire VPW link controller and the
//          controls they steer: receive ignore, prescaler, loopbacks,
//          interrupt gating, wait clocking and 4X receive.
// Assumes: One clock clk (oscillator clock), synchronous active-low reset;
//          the framing engine lives elsewhere and talks through the ports.
// Notes:   Every output comes from a flip-flop, so each lags its cause by
//          one clock.
`timescale 1ns/1ps
`include "vpw_link_consts.svh"

module vpw_link_control_regs
   import vpw_link_pkg::*;
#(
   parameter int IDLE_W = 16,
   parameter int EOF_CYCLES = (`EOF_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   parameter int IFS_CYCLES = (`IFS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [1:0] reg_addr,        // Register word index
   input wire logic [7:0] reg_wdata,       // Write data
   input wire logic reg_write,             // One-cycle write strobe
   input wire logic reg_read,              // One-cycle read strobe
   output logic [7:0] reg_rdata,           // Read data, cycle after read
   input wire logic sof_seen,              // Engine saw start of frame
   input wire logic break_seen,            // Engine saw BREAK symbol
   input wire logic [7:0] state_vector,    // Current state vector code
   input wire logic bus_rx_in,             // Receive from transceiver, 1 active
   input wire logic bus_edge,              // Edge seen on the bus pin
   input wire logic digital_tx_out,        // Transmit bit from the engine
   input wire logic cpu_wait,              // CPU is in wait mode
   output logic digital_rx_in,             // Receive bit into the engine
   output logic bus_tx_drive,              // Drive toward the transceiver
   output logic link_tick,                 // Prescaled timebase enable
   output logic timebase_select,           // 1 binary, 0 integer frequency
   output logic link_clk_run,              // Internal clocks running
   output logic rx_enable,                 // Receiver may take traffic
   output logic tx_enable,                 // Transmitter may start
   output logic status_hold,               // Status held at reset values
   output logic engine_reset,              // One-cycle engine reset pulse
   output logic fast_rx_mode,              // 4X receive-only accepted
   output logic sv_break_load,             // Load code 1C into state vector
   output logic wake_edge,                 // Bus wakeup event
   output logic irq,                       // CPU interrupt request
   output logic [3:0] tx_ctl_fields        // Low fields of register two
);

   // Register contents
   link_control_one_t ctl_one;
   link_control_two_t ctl_two;
   logic rate_locked;                      // Rate field already written once
   logic [2:0] div_cnt;                    // Prescaler count
   logic [IDLE_W-1:0] idle_cnt;            // Cycles of passive bus
   loop_state_t loop_state;

   // Count from which the prescaler wraps for a rate code
   function automatic logic [2:0] div_limit(input logic [1:0] code);
      case (code)
         2'h0: div_limit = 3'h0;
         2'h1: div_limit = 3'h1;
         2'h2: div_limit = 3'h3;
         default: div_limit = 3'h7;
      endcase
   endfunction

   // Address decode
   wire wr_one = reg_write && (reg_addr == `ADDR_CTL_ONE);
   wire wr_two = reg_write && (reg_addr == `ADDR_CTL_TWO);
   wire any_loop = ctl_two.transceiver_loopback || ctl_two.digital_loopback;

   // Idle thresholds; saturating counter so long idles never wrap
   wire eof_met = idle_cnt >= IDLE_W'(EOF_CYCLES);
   wire ifs_met = idle_cnt >= IDLE_W'(IFS_CYCLES);
   wire idle_top = &idle_cnt;

   // Next value of register one
   link_control_one_t next_one;
   always_comb begin
      next_one = ctl_one;
      if (wr_one) begin
         next_one = link_control_one_t'((reg_wdata & `C1_PLAIN_MASK)
                                        | (8'(ctl_one) & ~`C1_PLAIN_MASK));
         // Rate field takes only the first write after reset
         if (!rate_locked) begin
            next_one.rate_divider_high = reg_wdata[`C1_RATE_HIGH];
            next_one.rate_divider_low = reg_wdata[`C1_RATE_LOW];
         end
         next_one.spare = 2'h0;
      end else if (sof_seen || break_seen) begin
         // Software setting in the same cycle wins over the hardware clear
         next_one.receive_ignore = 1'b0;
      end
   end

   // Next value of register two
   link_control_two_t next_two;
   always_comb begin
      next_two = ctl_two;
      if (wr_two) begin
         next_two = link_control_two_t'(reg_wdata);
      end else if (break_seen) begin
         next_two.fast_receive_allow = 1'b0;
      end
   end

   // Read mux; status shows block state
   wire [7:0] status_word = {4'h0, rate_locked, rx_enable, tx_enable, any_loop};
   wire [7:0] next_rdata = (reg_addr == `ADDR_CTL_ONE) ? 8'(ctl_one) :
                           (reg_addr == `ADDR_CTL_TWO) ? 8'(ctl_two) :
                           (reg_addr == `ADDR_STATUS) ? status_word : 8'h00;

   // Loopback recovery state machine
   loop_state_t next_state;
   always_comb begin
      case (loop_state)
         st_normal: next_state = any_loop ? st_loop : st_normal;
         st_loop: next_state = any_loop ? st_loop : st_recover;
         st_recover: begin
            if (any_loop) begin
               next_state = st_loop;
            end else if (eof_met && ifs_met) begin
               next_state = st_normal;
            end else begin
               next_state = st_recover;
            end
         end
         default: next_state = st_loop;
      endcase
   end

   // Receiver and transmitter permission after loopback exit
   wire next_rx_en = !ctl_one.receive_ignore &&
                     ((loop_state != st_recover) || eof_met);
   wire next_tx_en = !ctl_two.fast_receive_allow &&
                     ((loop_state != st_recover) || ifs_met);

   // Interrupt: wakeup code passes ignore and allow, others need both
   wire sv_pending = state_vector != `SV_CODE_NONE;
   wire sv_wakeup = state_vector == `SV_CODE_WAKEUP;
   wire next_irq = sv_pending && (sv_wakeup ||
                   (!ctl_one.receive_ignore && ctl_one.irq_allow));

   // Register state
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ctl_one <= link_control_one_t'(`CTL_ONE_RESET);
         ctl_two <= link_control_two_t'(`CTL_TWO_RESET);
         rate_locked <= 1'b0;
         reg_rdata <= 8'h00;
         loop_state <= st_loop;
      end else begin
         ctl_one <= next_one;
         ctl_two <= next_two;
         rate_locked <= rate_locked || wr_one;
         reg_rdata <= reg_read ? next_rdata : 8'h00;
         loop_state <= next_state;
      end
   end

   // Prescaler: one tick per 1, 2, 4 or 8 oscillator cycles
   wire div_wrap = div_cnt >= div_limit({ctl_one.rate_divider_high,
                                         ctl_one.rate_divider_low});
   always_ff @(posedge clk) begin
      if (!resetn) begin
         div_cnt <= 3'h0;
         link_tick <= 1'b0;
      end else begin
         div_cnt <= div_wrap ? 3'h0 : div_cnt + 3'h1;
         link_tick <= div_wrap;
      end
   end

   // Idle counter; restarts on any active bus level or while looped
   always_ff @(posedge clk) begin
      if (!resetn) begin
         idle_cnt <= '0;
      end else if (bus_rx_in || any_loop) begin
         idle_cnt <= '0;
      end else if (!idle_top) begin
         idle_cnt <= idle_cnt + IDLE_W'(1);
      end
   end

   // Pin-side and engine-side outputs
   always_ff @(posedge clk) begin
      if (!resetn) begin
         digital_rx_in <= 1'b0;
         bus_tx_drive <= 1'b0;
         timebase_select <= 1'b0;
         link_clk_run <= 1'b1;
         rx_enable <= 1'b0;
         tx_enable <= 1'b0;
         status_hold <= 1'b0;
         engine_reset <= 1'b1;
         fast_rx_mode <= 1'b0;
         sv_break_load <= 1'b0;
         wake_edge <= 1'b0;
         irq <= 1'b0;
         tx_ctl_fields <= 4'h0;
      end else begin
         // Receive source chosen by digital loopback
         digital_rx_in <= ctl_two.digital_loopback ? digital_tx_out
                                                   : bus_rx_in;
         // Either loopback keeps the bus passive
         bus_tx_drive <= digital_tx_out && !any_loop;
         timebase_select <= ctl_one.timebase_select;
         link_clk_run <= !(cpu_wait && ctl_one.wait_clock_stop);
         rx_enable <= next_rx_en;
         tx_enable <= next_tx_en;
         status_hold <= ctl_one.receive_ignore;
         // Pulse on the write that turns transceiver loopback on
         engine_reset <= wr_two && reg_wdata[`C2_TRANSCEIVER_LOOPBACK]
                         && !ctl_two.transceiver_loopback;
         fast_rx_mode <= ctl_two.fast_receive_allow;
         sv_break_load <= break_seen;
         wake_edge <= bus_edge && !ctl_two.digital_loopback;
         irq <= next_irq;
         tx_ctl_fields <= 4'(ctl_two);
      end
   end

   // Checks

   // Ignore stays set until a frame start or break (or software)
   a_ignore_holds: assert property (@(posedge clk) disable iff (!resetn)
      ctl_one.receive_ignore && !sof_seen && !break_seen && !wr_one
      |=> ctl_one.receive_ignore)
      else $error("receive ignore dropped without cause");

   a_ignore_clear: assert property (@(posedge clk) disable iff (!resetn)
      (sof_seen || break_seen) && !wr_one |=> !ctl_one.receive_ignore)
      else $error("receive ignore not cleared by frame start");

   a_ignore_mask: assert property (@(posedge clk) disable iff (!resetn)
      ctl_one.receive_ignore && !sv_wakeup |=> !irq)
      else $error("interrupt not masked during ignore");

   a_rate_once: assert property (@(posedge clk) disable iff (!resetn)
      rate_locked |=> $stable({ctl_one.rate_divider_high, ctl_one.rate_divider_low}))
      else $error("rate field changed after lock");

   a_tick_period: assert property (@(posedge clk) disable iff (!resetn)
      link_tick && rate_locked && ctl_one.rate_divider_high && ctl_one.rate_divider_low
      |=> !link_tick [*7] ##1 link_tick)
      else $error("divide-by-eight period wrong");

   a_irq_pending: assert property (@(posedge clk) disable iff (!resetn)
      sv_pending && ctl_one.irq_allow && !ctl_one.receive_ignore |=> irq)
      else $error("pending source lost its request");

   a_loop_passive: assert property (@(posedge clk) disable iff (!resetn)
      ctl_two.transceiver_loopback |=> !bus_tx_drive)
      else $error("bus driven in transceiver loopback");

   a_loop_reset: assert property (@(posedge clk) disable iff (!resetn)
      wr_two && reg_wdata[`C2_TRANSCEIVER_LOOPBACK] && !ctl_two.transceiver_loopback
      |=> engine_reset ##1 !engine_reset)
      else $error("engine reset not pulsed");

   a_recover_rx: assert property (@(posedge clk) disable iff (!resetn)
      loop_state == st_recover && !eof_met |=> !rx_enable)
      else $error("receive allowed before idle time");

   a_digital_loopback_mux: assert property (@(posedge clk) disable iff (!resetn)
      ctl_two.digital_loopback |=> digital_rx_in == $past(digital_tx_out))
      else $error("loopback multiplexer wrong");

   a_digital_loopback_wake: assert property (@(posedge clk) disable iff (!resetn)
      ctl_two.digital_loopback |=> !wake_edge)
      else $error("wakeup passed in digital loopback");

   a_break_fast: assert property (@(posedge clk) disable iff (!resetn)
      break_seen && !wr_two |=> !ctl_two.fast_receive_allow ##1 !fast_rx_mode)
      else $error("break did not clear fast receive");

   a_fast_no_tx: assert property (@(posedge clk) disable iff (!resetn)
      ctl_two.fast_receive_allow |=> !tx_enable)
      else $error("transmit allowed in fast receive");

   // Transmit waits out the separator time after a loopback
   a_recover_tx: assert property (@(posedge clk) disable iff (!resetn)
      loop_state == st_recover && !ifs_met |=> !tx_enable)
      else $error("transmit allowed before idle time");

   // Ignore keeps the receiver closed, whatever the loop state
   a_ignore_rx: assert property (@(posedge clk) disable iff (!resetn)
      ctl_one.receive_ignore |=> !rx_enable)
      else $error("receiver open during ignore");

   // Status freeze follows the ignore control one cycle late
   a_status_hold: assert property (@(posedge clk) disable iff (!resetn)
      1'b1 |=> status_hold == $past(ctl_one.receive_ignore))
      else $error("status hold out of step with ignore");

   // Wakeup code is never masked
   a_wake_irq: assert property (@(posedge clk) disable iff (!resetn)
      sv_wakeup |=> irq)
      else $error("wakeup code did not raise request");

   // Allow clear masks every ordinary code
   a_irq_gate: assert property (@(posedge clk) disable iff (!resetn)
      !ctl_one.irq_allow && !sv_wakeup |=> !irq)
      else $error("request raised with interrupts disallowed");

   // No pending code, no request
   a_irq_idle: assert property (@(posedge clk) disable iff (!resetn)
      !sv_pending |=> !irq)
      else $error("request without pending code");

   // Timebase output mirrors its control bit
   a_time_copy: assert property (@(posedge clk) disable iff (!resetn)
      1'b1 |=> timebase_select == $past(ctl_one.timebase_select))
      else $error("timebase select not copied");

   // Rate code zero ticks on every clock
   a_tick_full: assert property (@(posedge clk) disable iff (!resetn)
      !ctl_one.rate_divider_high && !ctl_one.rate_divider_low |=> link_tick)
      else $error("divide-by-one tick missing");

   // Clocks stop only in wait with the stop control set
   a_wait_stop: assert property (@(posedge clk) disable iff (!resetn)
      cpu_wait && ctl_one.wait_clock_stop |=> !link_clk_run)
      else $error("clocks ran in wait with stop set");

   a_wait_run: assert property (@(posedge clk) disable iff (!resetn)
      !cpu_wait || !ctl_one.wait_clock_stop |=> link_clk_run)
      else $error("clocks stopped without cause");

   // Outside both loopbacks the bus follows the transmit bit
   a_tx_drive: assert property (@(posedge clk) disable iff (!resetn)
      !any_loop |=> bus_tx_drive == $past(digital_tx_out))
      else $error("bus drive does not follow transmit bit");

   // Digital loopback keeps the bus passive as well
   a_digital_loopback_passive: assert property (@(posedge clk) disable iff (!resetn)
      ctl_two.digital_loopback |=> !bus_tx_drive)
      else $error("bus driven in digital loopback");

   // Without digital loopback the receiver hears the bus
   a_bus_mux: assert property (@(posedge clk) disable iff (!resetn)
      !ctl_two.digital_loopback |=> digital_rx_in == $past(bus_rx_in))
      else $error("receive input not taken from bus");

   // Bus edges wake the controller unless looped digitally
   a_wake_pass: assert property (@(posedge clk) disable iff (!resetn)
      bus_edge && !ctl_two.digital_loopback |=> wake_edge)
      else $error("bus edge did not reach wakeup");

   // BREAK asks for the break code one cycle later
   a_break_load: assert property (@(posedge clk) disable iff (!resetn)
      break_seen |=> sv_break_load)
      else $error("break code load missing");

   // Fast receive output mirrors its control bit
   a_fast_copy: assert property (@(posedge clk) disable iff (!resetn)
      1'b1 |=> fast_rx_mode == $past(ctl_two.fast_receive_allow))
      else $error("fast receive mode not copied");

endmodule

// >>> vpw_link_consts.svh
// Purpose: Named offsets, field positions, reset values and times of the
//          link control-register block.
// Assumes: Included by its bare name from the package and the module.
// Notes:   Definitions only.
`ifndef VPW_LINK_CONSTS_SVH
`define VPW_LINK_CONSTS_SVH

// Register word indices on the plain register port
`define ADDR_CTL_ONE 2'h0
`define ADDR_CTL_TWO 2'h1
`define ADDR_STATUS 2'h2

// Reset values
`define CTL_ONE_RESET 8'h00
`define CTL_TWO_RESET 8'hc0

// Field positions of link_control_one
`define C1_RECEIVE_IGNORE 7
`define C1_TIMEBASE_SELECT 6
`define C1_RATE_HIGH 5
`define C1_RATE_LOW 4
`define C1_IRQ_ALLOW 1
`define C1_WAIT_CLOCK_STOP 0
// Writable mask of link_control_one (rate field handled apart)
`define C1_PLAIN_MASK 8'hc3

// Field positions of link_control_two
`define C2_TRANSCEIVER_LOOPBACK 7
`define C2_DIGITAL_LOOPBACK 6
`define C2_FAST_RECEIVE 5

// State vector codes
`define SV_CODE_WAKEUP 8'h20
`define SV_CODE_NONE 8'h00

// Timing
`define CLK_PERIOD_NS 40
`define EOF_TIME_NS 280000
`define IFS_TIME_NS 300000

`endif

// >>> vpw_link_pkg.sv
// Purpose: Types shared by the link control-register block.
// Assumes: Constants come from vpw_link_consts.svh.
// Notes:   Field order matches the bit positions in the header.
package vpw_link_pkg;
`include "vpw_link_consts.svh"

   // Control register one, bit 7 down to bit 0
   typedef struct packed {
      logic receive_ignore;
      logic timebase_select;
      logic rate_divider_high;
      logic rate_divider_low;
      logic [1:0] spare;
      logic irq_allow;
      logic wait_clock_stop;
   } link_control_one_t;

   // Control register two, bit 7 down to bit 0
   typedef struct packed {
      logic transceiver_loopback;
      logic digital_loopback;
      logic fast_receive_allow;
      logic norm_bit_format;
      logic send_end_of_data;
      logic single_byte_response_req;
      logic multi_byte_response_crc_req;
      logic multi_byte_response_req;
   } link_control_two_t;

   // Loopback recovery state, Gray along normal -> loop -> recover
   typedef enum logic [1:0] {
      st_normal = 2'b00,
      st_loop = 2'b01,
      st_recover = 2'b11
   } loop_state_t;
endpackage

// >>> vpw_bus_model.sv
// Purpose: Behavioural single-wire bus with its transceiver, as the link block sees it.
// Assumes: Active level is 1; the passive bus is pulled to 0 when nobody drives.
// Notes:   Other nodes are one level input; edges come out as one-cycle pulses.
`timescale 1ns/1ps
module vpw_bus_model (
   input wire logic clk,
   input wire logic drive,
   input wire logic other_talk,
   output logic bus_rx_in,
   output logic bus_edge
);
   logic last = 1'b0; // Bus level seen one clock ago

   // Wired-OR bus: any driver makes it active, else the pull-down wins
   assign bus_rx_in = drive | other_talk;

   // Edge detector feeding the wakeup input
   always @(posedge clk) begin
      bus_edge <= bus_rx_in ^ last;
      last <= bus_rx_in;
   end
endmodule

// >>> tb_vpw_link_control_regs.sv
// Purpose: Self-checking bench of the link control-register block.
// Assumes: Idle waits shortened to 5 and 6 cycles so the run stays small.
// Notes:   Random data from an xorshift seeded with 56777; every read is checked.
`timescale 1ns/1ps
`include "vpw_link_consts.svh"
module tb_vpw_link_control_regs;
   import vpw_link_pkg::*;
   logic clk = 1'b0, resetn = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
   logic [1:0] reg_addr = 2'h0;
   logic [7:0] reg_wdata = 8'h00, state_vector = 8'h00, d;
   logic sof_seen = 1'b0, break_seen = 1'b0, digital_tx_out = 1'b0, cpu_wait = 1'b0;
   logic other_talk = 1'b0; // Traffic of other nodes on the bus
   logic bus_rx_in, bus_edge, digital_rx_in, bus_tx_drive, link_tick, timebase_select;
   logic link_clk_run, rx_enable, tx_enable, status_hold, engine_reset, fast_rx_mode;
   logic sv_break_load, wake_edge, irq;
   logic [7:0] reg_rdata;
   logic [3:0] tx_ctl_fields;
   logic [31:0] rng = 32'hddc9; // Fixed seed keeps runs repeatable
   int bad_count = 0, total_checks = 0, n;

   always #20 clk = ~clk; // 25 MHz

   vpw_link_control_regs #(.EOF_CYCLES(5), .IFS_CYCLES(6)) DUT (.clk, .resetn, .reg_addr,
      .reg_wdata, .reg_write, .reg_read, .reg_rdata, .sof_seen, .break_seen, .state_vector,
      .bus_rx_in, .bus_edge, .digital_tx_out, .cpu_wait, .digital_rx_in, .bus_tx_drive,
      .link_tick, .timebase_select, .link_clk_run, .rx_enable, .tx_enable, .status_hold,
      .engine_reset, .fast_rx_mode, .sv_break_load, .wake_edge, .irq, .tx_ctl_fields);
   vpw_bus_model bus (.clk, .drive(bus_tx_drive), .other_talk, .bus_rx_in, .bus_edge);

   // Next pseudo-random word
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction

   // Link ticks expected in a window for a rate code
   function automatic logic [7:0] ticks_for(input int code, input int span);
      return 8'(span >> code);
   endfunction

   // One comparison of any value up to a byte
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Register write: strobe held through exactly one sampling edge
   task automatic wr(input logic [1:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask

   // Register read: data stands only in the cycle after the strobe
   task automatic rd(input logic [1:0] a, output logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1 v = reg_rdata;
   endtask

   // Let k edges pass, then sample settled outputs
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   // Synchronous reset held four cycles, outputs checked while it holds
   task automatic do_reset;
      @(posedge clk);
      resetn <= 1'b0;
      cyc(3);
      chk(8'({engine_reset, link_clk_run, irq, rx_enable}), 8'h0c);
      @(posedge clk);
      resetn <= 1'b1;
   endtask

   // Engine event pulse of one cycle
   task automatic pulse_break;
      @(posedge clk);
      break_seen <= 1'b1;
      @(posedge clk);
      break_seen <= 1'b0;
      #1;
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Hang guard, far beyond the few hundred cycles the tests need
   initial begin
      #(40 * 4000);
      bad_count++;
      finish_test;
   end

   initial begin
      do_reset;
      rd(`ADDR_CTL_TWO, d); chk(d, 8'hc0);
      rd(`ADDR_CTL_ONE, d); chk(d, 8'h00);
      rd(2'h3, d); chk(d, 8'h00);
      // Both loopbacks on: random transmit bits and bus noise
      for (int i = 0; i < 8; i++) begin
         rng = xs(rng);
         @(posedge clk);
         digital_tx_out <= rng[0];
         other_talk <= rng[1];
         cyc(2);
         chk(8'({digital_rx_in, bus_tx_drive, wake_edge}), 8'({rng[0], 2'b00}));
      end
      // Both loopbacks cleared first; only the transceiver control then rises
      wr(`ADDR_CTL_TWO, 8'h00);
      digital_tx_out <= 1'b1;
      wr(`ADDR_CTL_TWO, 8'h80);
      // The pulse stands only in the cycle right after the write edge
      #1 n = engine_reset;
      repeat (3) begin
         cyc(1);
         n += engine_reset;
      end
      chk(8'(n), 8'h01);
      chk(8'(bus_tx_drive), 8'h00);
      // Leave loopback on a quiet bus: receive waits EOF, transmit IFS
      rng = xs(rng);
      @(posedge clk);
      digital_tx_out <= 1'b0;
      other_talk <= 1'b0;
      wr(`ADDR_CTL_TWO, {4'h0, rng[3:0]});
      cyc(2);
      chk(8'({rx_enable, tx_enable}), 8'h00);
      chk(8'(tx_ctl_fields), 8'(rng[3:0]));
      n = 0;
      while (rx_enable !== 1'b1 && n < 20) begin
         cyc(1);
         n++;
      end
      chk(8'({rx_enable, tx_enable}), 8'h02);
      cyc(2);
      chk(8'(tx_enable), 8'h01);
      rd(`ADDR_STATUS, d); chk(d, 8'h06);
      // Bus path live again: receive follows the bus, edges wake
      @(posedge clk);
      other_talk <= 1'b1;
      digital_tx_out <= 1'b1;
      cyc(1);
      n = 0;
      repeat (3) begin
         cyc(1);
         n += wake_edge;
      end
      chk(8'({n[1:0], digital_rx_in, bus_tx_drive}), 8'h07);
      @(posedge clk);
      other_talk <= 1'b0;
      digital_tx_out <= 1'b0;
      // Fast receive drops transmit; BREAK clears it and loads the code
      wr(`ADDR_CTL_TWO, 8'h20);
      cyc(2);
      chk(8'({fast_rx_mode, tx_enable}), 8'h02);
      pulse_break;
      chk(8'(sv_break_load), 8'h01);
      cyc(1);
      chk(8'({fast_rx_mode, sv_break_load, tx_enable}), 8'h01);
      // Ignore masks all but the wakeup code and holds status
      @(posedge clk);
      state_vector <= 8'h05;
      wr(`ADDR_CTL_ONE, 8'h82);
      cyc(2);
      chk(8'({rx_enable, status_hold, irq}), 8'h02);
      @(posedge clk);
      state_vector <= 8'h20;
      cyc(2);
      chk(8'(irq), 8'h01);
      @(posedge clk);
      state_vector <= 8'h05;
      sof_seen <= 1'b1;
      @(posedge clk);
      sof_seen <= 1'b0;
      cyc(2);
      chk(8'({rx_enable, status_hold, irq}), 8'h05);
      rd(`ADDR_CTL_ONE, d); chk(d, 8'h02);
      wr(`ADDR_CTL_ONE, 8'h00);
      cyc(2);
      chk(8'(irq), 8'h00);
      wr(`ADDR_CTL_ONE, 8'h82);
      pulse_break;
      cyc(2);
      chk(8'({status_hold, irq}), 8'h01);
      @(posedge clk);
      state_vector <= 8'h00;
      cyc(2);
      chk(8'(irq), 8'h00);
      // Timebase copy and wait-mode clock stop
      @(posedge clk);
      cpu_wait <= 1'b1;
      wr(`ADDR_CTL_ONE, 8'h41);
      cyc(2);
      chk(8'({timebase_select, link_clk_run}), 8'h02);
      wr(`ADDR_CTL_ONE, 8'h40);
      cyc(2);
      chk(8'(link_clk_run), 8'h01);
      // Every divider code: first write sticks, second is refused
      for (int c = 0; c < 4; c++) begin
         do_reset;
         wr(`ADDR_CTL_ONE, {2'b00, 2'(c), 4'h0});
         wr(`ADDR_CTL_ONE, {2'b00, ~2'(c), 4'h0});
         rd(`ADDR_CTL_ONE, d); chk(d, {2'b00, 2'(c), 4'h0});
         cyc(2);
         n = 0;
         repeat (32) begin
            cyc(1);
            n += link_tick;
         end
         chk(8'(n), ticks_for(c, 32));
      end
      finish_test;
   end
endmodule
